// ===== logic/lsis_core_tail.sv
// Decode and execute of the exclusive-OR, nibble-swap and direction-load instructions
//
// Contract
// - The literal exclusive-OR folds the 8-bit literal into the accumulator and updates the zero flag.
// - The register exclusive-OR combines accumulator and file register, updates zero, and writes to d.
// - The direction-load copies the accumulator into direction register 5 to 7, leaving flags alone.
// - The direction registers are also plain file registers that normal instructions read and write.
`timescale 1ns/10ps
module lsis_core_tail
   import lsis_pkg::*;
(
   // Clock and reset
   input  wire logic                         clk_sys,
   input  wire logic                         resetn,
   // Instruction issue
   input  wire logic                         instr_valid,
   input  wire logic [lsis_pkg::INSTR_W-1:0] instr_word,
   // Core state
   output logic      [lsis_pkg::DATA_W-1:0]  accum_q,
   output logic                              zero_flag_q,
   output logic      [lsis_pkg::DATA_W-1:0]  dir_reg_q [lsis_pkg::DIR_COUNT],
   // Retire status
   output logic                              retire_q,
   output logic                              bad_operand_q
);
   import lsis_pkg::*;

   // Decode of a raw instruction word
   function automatic lsis_op_e op_decode(input logic [INSTR_W-1:0] word);
      lsis_op_e op;
      op = OP_NONE;
      if (word[OPC6_MSB:OPC6_LSB] == OPC_LIT_XOR) begin
         op = OP_LIT_XOR;
      end else if (word[OPC6_MSB:OPC6_LSB] == OPC_REG_XOR) begin
         op = OP_REG_XOR;
      end else if (word[OPC6_MSB:OPC6_LSB] == OPC_SWAP) begin
         op = OP_SWAP;
      end else if (word[OPC6_MSB:OPC11_LSB] == OPC_DIR_LD) begin
         op = OP_DIR_LD;
      end
      return op;
   endfunction : op_decode

   // True when a file address lands on a direction register
   function automatic logic is_dir_addr(input logic [FADDR_W-1:0] addr);
      return (addr >= DIR_FADDR0) && (addr < DIR_FADDR0 + 7'(DIR_COUNT));
   endfunction : is_dir_addr

   // Index of the direction register behind a file address
   function automatic logic [1:0] dir_index(input logic [FADDR_W-1:0] addr);
      logic [FADDR_W-1:0] off;
      off = addr - DIR_FADDR0;
      return off[1:0];
   endfunction : dir_index

   // Stage registers between fetch of the operand and execute
   logic                s1_valid_q;
   lsis_op_e            s1_op_q;
   logic [INSTR_W-1:0]  s1_word_q;
   logic [DATA_W-1:0]   mem_rdata;

   // Execute-stage signals
   logic [FADDR_W-1:0]  ex_faddr;
   logic                ex_dest;
   logic [DATA_W-1:0]   ex_operand;
   logic [DATA_W-1:0]   ex_result;
   logic                ex_to_file;
   logic                ex_to_acc;
   logic                ex_set_zero;
   logic                ex_dir_ld_ok;
   logic [1:0]          ex_dir_ld_idx;
   logic                mem_wr_en;

   // Operand read is launched as the instruction is taken
   lsis_file_mem #(
      .WIDTH (DATA_W),
      .DEPTH (FILE_DEPTH),
      .AW    (FADDR_W)
   ) u_file_mem (
      .clk_sys   (clk_sys),
      .rd_en     (instr_valid),
      .rd_addr   (instr_word[FADDR_MSB:0]),
      .rd_data_q (mem_rdata),
      .wr_en     (mem_wr_en),
      .wr_addr   (ex_faddr),
      .wr_data   (ex_result)
   );

   // Issue stage
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         s1_valid_q <= 1'b0;
         s1_op_q    <= OP_NONE;
         s1_word_q  <= '0;
      end else begin
         s1_valid_q <= instr_valid;
         s1_op_q    <= instr_valid ? op_decode(instr_word) : OP_NONE;
         s1_word_q  <= instr_word;
      end
   end

   // Operand select; direction registers shadow the array at their addresses
   always_comb begin
      ex_faddr   = s1_word_q[FADDR_MSB:0];
      ex_dest    = s1_word_q[DEST_BIT];
      ex_operand = mem_rdata;
      if (is_dir_addr(ex_faddr)) begin
         ex_operand = dir_reg_q[dir_index(ex_faddr)];
      end
   end

   // Result and destination per operation
   always_comb begin
      ex_result     = accum_q;
      ex_to_file    = 1'b0;
      ex_to_acc     = 1'b0;
      ex_set_zero   = 1'b0;
      ex_dir_ld_ok  = 1'b0;
      ex_dir_ld_idx = 2'h0;
      case (s1_op_q)
         OP_LIT_XOR: begin
            ex_result   = accum_q ^ s1_word_q[LIT_MSB:0];
            ex_to_acc   = 1'b1;
            ex_set_zero = 1'b1;
         end
         OP_REG_XOR: begin
            ex_result   = accum_q ^ ex_operand;
            ex_to_acc   = !ex_dest;
            ex_to_file  = ex_dest;
            ex_set_zero = 1'b1;
         end
         OP_SWAP: begin
            ex_result  = {ex_operand[3:0], ex_operand[7:4]};
            ex_to_acc  = !ex_dest;
            ex_to_file = ex_dest;
         end
         OP_DIR_LD: begin
            ex_dir_ld_ok  = (s1_word_q[DSEL_MSB:0] >= DSEL_FIRST) && (s1_word_q[DSEL_MSB:0] <= DSEL_LAST);
            ex_dir_ld_idx = 2'(s1_word_q[DSEL_MSB:0] - DSEL_FIRST);
         end
         default: begin
            ex_result = accum_q;
         end
      endcase
   end

   // Array writes skip the direction addresses, which live in flops
   assign mem_wr_en = s1_valid_q && ex_to_file && !is_dir_addr(ex_faddr);

   // Accumulator
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         accum_q <= ACC_RST;
      end else if (s1_valid_q && ex_to_acc) begin
         accum_q <= ex_result;
      end
   end

   // Zero flag, touched only by the exclusive-OR forms
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         zero_flag_q <= ZERO_RST;
      end else if (s1_valid_q && ex_set_zero) begin
         zero_flag_q <= (ex_result == '0);
      end
   end

   // Direction registers: legacy load or ordinary file-register write
   generate
      for (genvar gi = 0; gi < DIR_COUNT; gi++) begin : g_dir
         always_ff @(posedge clk_sys or negedge resetn) begin
            if (!resetn) begin
               dir_reg_q[gi] <= DIR_RST;
            end else if (s1_valid_q && ex_dir_ld_ok && (ex_dir_ld_idx == 2'(gi))) begin
               dir_reg_q[gi] <= accum_q;
            end else if (s1_valid_q && ex_to_file && is_dir_addr(ex_faddr)
                         && (dir_index(ex_faddr) == 2'(gi))) begin
               dir_reg_q[gi] <= ex_result;
            end
         end
      end
   endgenerate

   // Retire pulse and out-of-range direction operand pulse
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         retire_q      <= 1'b0;
         bad_operand_q <= 1'b0;
      end else begin
         retire_q      <= s1_valid_q && (s1_op_q != OP_NONE) && !((s1_op_q == OP_DIR_LD) && !ex_dir_ld_ok);
         bad_operand_q <= s1_valid_q && (s1_op_q == OP_DIR_LD) && !ex_dir_ld_ok;
      end
   end

   // Checks on the executed results
   lit_xor_acc_a: assert property (@(posedge clk_sys) disable iff (!resetn)
      s1_valid_q && (s1_op_q == OP_LIT_XOR) |=> (accum_q == ($past(accum_q) ^ $past(s1_word_q[LIT_MSB:0])))
      && (zero_flag_q == (accum_q == 8'h00)))
      else $error("literal exclusive-OR result wrong");

   reg_xor_acc_a: assert property (@(posedge clk_sys) disable iff (!resetn)
      s1_valid_q && (s1_op_q == OP_REG_XOR) && !s1_word_q[DEST_BIT]
      |=> (accum_q == ($past(accum_q) ^ $past(ex_operand))) && (zero_flag_q == (accum_q == 8'h00)))
      else $error("register exclusive-OR to accumulator wrong");

   reg_xor_file_a: assert property (@(posedge clk_sys) disable iff (!resetn)
      s1_valid_q && (s1_op_q == OP_REG_XOR) && s1_word_q[DEST_BIT]
      |=> $stable(accum_q) && (zero_flag_q == (($past(accum_q) ^ $past(ex_operand)) == 8'h00)))
      else $error("register exclusive-OR to file disturbed accumulator or zero");

   dir_load_a: assert property (@(posedge clk_sys) disable iff (!resetn)
      s1_valid_q && (s1_op_q == OP_DIR_LD) && (s1_word_q[DSEL_MSB:0] == 3'h6)
      |=> (dir_reg_q[1] == $past(accum_q)) && $stable(zero_flag_q) && $stable(accum_q))
      else $error("direction load did not copy accumulator");

   dir_bad_sel_a: assert property (@(posedge clk_sys) disable iff (!resetn)
      s1_valid_q && (s1_op_q == OP_DIR_LD) && (s1_word_q[DSEL_MSB:0] < 3'h5)
      |=> bad_operand_q && !retire_q && $stable(dir_reg_q[0]) && $stable(dir_reg_q[1]) && $stable(dir_reg_q[2]))
      else $error("illegal direction operand changed state");

   dir_file_wr_a: assert property (@(posedge clk_sys) disable iff (!resetn)
      s1_valid_q && (s1_op_q == OP_SWAP) && s1_word_q[DEST_BIT] && (s1_word_q[FADDR_MSB:0] == 7'h07)
      |=> dir_reg_q[2] == {$past(dir_reg_q[2][3:0]), $past(dir_reg_q[2][7:4])})
      else $error("swap to direction register not applied");

   swap_acc_a: assert property (@(posedge clk_sys) disable iff (!resetn)
      s1_valid_q && (s1_op_q == OP_SWAP) && !s1_word_q[DEST_BIT]
      |=> (accum_q == {$past(ex_operand[3:0]), $past(ex_operand[7:4])}) && $stable(zero_flag_q))
      else $error("nibble swap to accumulator wrong");

   retire_a: assert property (@(posedge clk_sys) disable iff (!resetn)
      instr_valid && (instr_word[OPC6_MSB:OPC6_LSB] == OPC_LIT_XOR) |=> ##1 retire_q)
      else $error("instruction did not retire in two cycles");

endmodule : lsis_core_tail

// ===== logic/lsis_file_mem.sv
// File-register array with registered, write-first read data
`timescale 1ns/10ps
module lsis_file_mem #(
   parameter int unsigned WIDTH = 8,
   parameter int unsigned DEPTH = 128,
   parameter int unsigned AW    = 7
) (
   // Clock
   input  wire logic             clk_sys,
   // Read port
   input  wire logic             rd_en,
   input  wire logic [AW-1:0]    rd_addr,
   output logic      [WIDTH-1:0] rd_data_q,
   // Write port
   input  wire logic             wr_en,
   input  wire logic [AW-1:0]    wr_addr,
   input  wire logic [WIDTH-1:0] wr_data
);

   logic [WIDTH-1:0] mem_q [DEPTH];

   // Array write
   always_ff @(posedge clk_sys) begin
      if (wr_en) begin
         mem_q[wr_addr] <= wr_data;
      end
   end

   // Read register; a same-edge write to the same word is passed through
   always_ff @(posedge clk_sys) begin
      if (rd_en) begin
         if (wr_en && (wr_addr == rd_addr)) begin
            rd_data_q <= wr_data;
         end else begin
            rd_data_q <= mem_q[rd_addr];
         end
      end
   end

endmodule : lsis_file_mem

// ===== logic/lsis_pkg.sv
// Shared constants, opcode patterns and types for the instruction tail subset
package lsis_pkg;

   // Widths
   localparam int unsigned INSTR_W     = 14;
   localparam int unsigned DATA_W      = 8;
   localparam int unsigned FADDR_W     = 7;
   localparam int unsigned FILE_DEPTH  = 128;
   localparam int unsigned DIR_COUNT   = 3;

   // Opcode field positions
   localparam int unsigned OPC6_MSB    = 13;
   localparam int unsigned OPC6_LSB    = 8;
   localparam int unsigned OPC11_LSB   = 3;
   localparam int unsigned DEST_BIT    = 7;
   localparam int unsigned FADDR_MSB   = 6;
   localparam int unsigned LIT_MSB     = 7;
   localparam int unsigned DSEL_MSB    = 2;

   // Opcode patterns
   localparam logic [5:0]  OPC_LIT_XOR = 6'h3a;
   localparam logic [5:0]  OPC_REG_XOR = 6'h06;
   localparam logic [5:0]  OPC_SWAP    = 6'h0e;
   localparam logic [10:0] OPC_DIR_LD  = 11'h00c;

   // Direction-load operand range and file-register placement
   localparam logic [2:0]  DSEL_FIRST  = 3'h5;
   localparam logic [2:0]  DSEL_LAST   = 3'h7;
   localparam logic [6:0]  DIR_FADDR0  = 7'h05;

   // Reset values
   localparam logic [7:0]  ACC_RST     = 8'h00;
   localparam logic [7:0]  DIR_RST     = 8'hff;
   localparam logic        ZERO_RST    = 1'b0;

   typedef enum logic [2:0] {
      OP_NONE,
      OP_LIT_XOR,
      OP_REG_XOR,
      OP_SWAP,
      OP_DIR_LD
   } lsis_op_e;

endpackage : lsis_pkg

// ===== tb/testbench.sv
// Self-checking testbench for the exclusive-OR, nibble-swap and direction-load subset
`timescale 1ns/10ps
module testbench;
   import lsis_pkg::*;
   logic               clk_sys;
   logic               resetn;
   logic               instr_valid;
   logic [INSTR_W-1:0] instr_word;
   logic [DATA_W-1:0]  accum_q;
   logic               zero_flag_q;
   logic [DATA_W-1:0]  dir_reg_q [DIR_COUNT];
   logic               retire_q;
   logic               bad_operand_q;
   int                 error_cnt;
   int                 n_compared;
   logic [7:0]         mw;
   logic               mz;
   logic [7:0]         md [3];

   lsis_core_tail dut (
      .clk_sys       (clk_sys),
      .resetn        (resetn),
      .instr_valid   (instr_valid),
      .instr_word    (instr_word),
      .accum_q       (accum_q),
      .zero_flag_q   (zero_flag_q),
      .dir_reg_q     (dir_reg_q),
      .retire_q      (retire_q),
      .bad_operand_q (bad_operand_q)
   );

   // Clock at 50 ns period
   initial begin
      clk_sys = 1'b0;
      forever #25 clk_sys = ~clk_sys;
   end

   task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
      n_compared++;
      if (seen !== exp) begin
         error_cnt++;
         $display("FAIL %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk

   // Expected effect of one word on accumulator, zero flag and direction registers
   task automatic model(input logic [13:0] wd, output logic ret, output logic bad);
      logic [7:0] v;
      ret = 1'b1;
      bad = 1'b0;
      v = md[wd[2:0] - 3'h5];
      case (wd[13:8])
         6'h3a: begin
            mw = mw ^ wd[7:0];
            mz = (mw == 8'h00);
         end
         6'h06, 6'h0e: begin
            v = (wd[13:8] == 6'h06) ? (v ^ mw) : {v[3:0], v[7:4]};
            if (wd[13:8] == 6'h06) mz = (v == 8'h00);
            if (wd[7]) md[wd[2:0] - 3'h5] = v;
            else mw = v;
         end
         default: begin
            if (wd[13:3] == 11'h00c && wd[2:0] >= 3'h5) md[wd[2:0] - 3'h5] = mw;
            else begin
               ret = 1'b0;
               bad = (wd[13:3] == 11'h00c);
            end
         end
      endcase
   endtask : model

   task automatic chk_state();
      chk("accum", accum_q, mw);
      chk("zero flag", {7'h00, zero_flag_q}, {7'h00, mz});
      for (int i = 0; i < 3; i++) chk("direction reg", dir_reg_q[i], md[i]);
   endtask : chk_state

   // Issue one word at a falling edge; it is taken at the next rising edge and shows after the one after
   task automatic exec(input logic [13:0] wd);
      logic ret;
      logic bad;
      model(wd, ret, bad);
      instr_valid = 1'b1;
      instr_word  = wd;
      @(negedge clk_sys);
      instr_valid = 1'b0;
      chk("retire early", {7'h00, retire_q}, 8'h00);
      @(negedge clk_sys);
      chk("retire", {7'h00, retire_q}, {7'h00, ret});
      chk("bad operand", {7'h00, bad_operand_q}, {7'h00, bad});
      chk_state();
   endtask : exec

   // Two words on consecutive edges; the second sees the first's result
   task automatic b2b(input logic [13:0] wa, input logic [13:0] wb);
      logic r;
      logic b;
      model(wa, r, b);
      instr_valid = 1'b1;
      instr_word  = wa;
      @(negedge clk_sys);
      instr_word = wb;
      @(negedge clk_sys);
      instr_valid = 1'b0;
      chk("retire first", {7'h00, retire_q}, {7'h00, r});
      chk_state();
      model(wb, r, b);
      @(negedge clk_sys);
      chk("retire second", {7'h00, retire_q}, {7'h00, r});
      chk_state();
   endtask : b2b

   task automatic t_lit_xor();
      exec(14'h3ab5);
      exec(14'h3aaf);
      exec(14'h3a1a);
   endtask : t_lit_xor

   task automatic t_dir_load();
      exec(14'h3a3c);
      for (int s = 0; s < 8; s++) exec(14'h0060 | 14'(s));
   endtask : t_dir_load

   task automatic t_reg_xor();
      exec(14'h0605);
      exec(14'h0687);
      exec(14'h3a3c);
      exec(14'h0686);
   endtask : t_reg_xor

   task automatic t_swap();
      exec(14'h3a99);
      exec(14'h0065);
      exec(14'h3aa5);
      exec(14'h0e05);
      exec(14'h0e85);
      exec(14'h0e87);
   endtask : t_swap

   task automatic t_b2b();
      b2b(14'h3a0f, 14'h0687);
      b2b(14'h0687, 14'h0e07);
      exec(14'h0000);
   endtask : t_b2b

   task automatic final_report();
      if (error_cnt == 0 && n_compared > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : final_report

   // Watchdog well beyond the expected run of some 63 cycles
   initial begin
      #(2000 * 50);
      error_cnt++;
      final_report();
   end

   // Main sequence
   initial begin
      error_cnt   = 0;
      n_compared  = 0;
      resetn      = 1'b0;
      instr_valid = 1'b0;
      instr_word  = 14'h0000;
      mw = ACC_RST;
      mz = ZERO_RST;
      md = '{DIR_RST, DIR_RST, DIR_RST};
      repeat (10) @(negedge clk_sys);
      chk_state();
      resetn = 1'b1;
      @(negedge clk_sys);
      t_lit_xor();
      t_dir_load();
      t_reg_xor();
      t_swap();
      t_b2b();
      final_report();
   end
endmodule : testbench
